// *** rtl/rss_pkg.sv ***
/*
 package for the reset strap sampler: strap field layout, defaults,
 register map of the control/status registers reached over axi4-lite.
 assumes a single 125 mhz system clock domain.
*/
package rss_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CLK_MHZ = 125;
   // least hold time of hardware reset, ns, and derived cycle count
   localparam int RST_MIN_NS = 1000;
   localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_STRAP_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PORT_A = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PORT_B = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SCRATCH = 8'h0c;
   // port status field positions
   localparam int F_ADDR_LSB = 0;
   localparam int F_FIBER = 8;
   localparam int F_AUTONEG = 9;
   localparam int F_CAP_LSB = 10;
   localparam int F_FULL_DUPLEX = 12;
   localparam int F_SPEED100 = 13;
   localparam int F_LATCHED = 16;
   // pin defaults (internal pulls): address low, fiber low, autoneg straps high
   localparam logic [3:0] DEF_ADDR = 4'h0;
   localparam logic DEF_FIBER = 1'b0;
   localparam logic DEF_AUTONEG = 1'b1;
   localparam logic [1:0] DEF_CAP = 2'h3;
   localparam logic [1:0] BRESP_OKAY = 2'h0;
   localparam logic [1:0] BRESP_SLVERR = 2'h2;
   localparam logic [DATA_W-1:0] SCRATCH_RST = 32'h00000000;

   // raw straps of one port
   typedef struct packed {
      logic fiber;
      logic autoneg;
      logic cap_high;
      logic cap_low;
   } rss_port_strap_t;

   // resolved operating configuration of one port
   typedef struct packed {
      logic [4:0] mgmt_addr;
      logic fiber;
      logic autoneg;
      logic [1:0] capability;
      logic full_duplex;
      logic speed100;
   } rss_port_cfg_t;

   // axi4-lite slave channels
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } rss_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } rss_axil_rsp_t;
endpackage

// *** rtl/rss_sync2.sv ***
/*
 two flip-flop synchroniser for a bundle of pin levels.
 assumes inputs are asynchronous to clk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module rss_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [WIDTH-1:0] d_in,
   input wire logic [WIDTH-1:0] rst_val_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] unused_rst_val;

   assign unused_rst_val = rst_val_in;

   // resets to zero; both stages hold zero while nrst_in is low, even with clocks running
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule // rss_sync2

// *** rtl/rss_top.sv ***
/*
 reset strap sampler: watches the strap pins of a dual 10/100 transceiver
 while hardware reset is held, freezes them at release and resolves each
 port's management address and operating mode. axi4-lite slave for status.
 assumes SYS_CLK_IN runs during reset, straps are stable pulls on the pins,
 and reset stays low for at least the documented minimum hold time.
*/
`timescale 1ns/1ps
// Overview of operation
// (R1) strap pin levels are sampled while hardware reset is active
// (R2) values are frozen at reset release, before pins take normal functions
// (R3) four strapped address bits form management address bits four to one
// (R4) address bit zero is not strapped; it picks port a or port b
// (R5) port a answers at the even address, range 0 to 30
// (R6) port b answers at the odd address, range 1 to 31
// (R7) each port has a fiber strap; high enables fiber, low disables
// (R8) autoneg strap high runs autoneg with capability; low forces capability
// (R9) the two capability straps give forced or advertised mode
// (R10) in fiber mode the low capability strap alone picks duplex
// (R11) in fiber mode autoneg and high capability straps are ignored
// (R12) fiber mode runs only at 100 mb/s and never autonegotiates
// (R13) latched values stay constant until the next hardware reset
module rss_top
   import rss_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   input wire logic [3:0] STRAP_MGMT_ADDRESS_BITS_IN,
   input wire rss_pkg::rss_port_strap_t STRAP_PORT_A_IN,
   input wire rss_pkg::rss_port_strap_t STRAP_PORT_B_IN,
   input wire rss_pkg::rss_axil_req_t AXIL_REQ_IN,
   output rss_pkg::rss_axil_rsp_t AXIL_RSP_OUT,
   output rss_pkg::rss_port_cfg_t PORT_A_CFG_OUT,
   output rss_pkg::rss_port_cfg_t PORT_B_CFG_OUT,
   output logic CFG_VALID_OUT
);
   import rss_pkg::*;

   localparam int PIN_W = 12;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_sync;
   logic [PIN_W-1:0] pin_rst_val;
   logic sampling;
   logic [3:0] phy_control_register;
   rss_port_strap_t strap_a;
   rss_port_strap_t strap_b;
   rss_port_cfg_t next_cfg_a;
   rss_port_cfg_t next_cfg_b;
   logic [DATA_W-1:0] scratch;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic [3:0] w_strb;
   logic [DATA_W-1:0] next_rdata;
   logic [1:0] next_rresp;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [DATA_W-1:0] rdata;
   logic [1:0] rresp;

   // pins gathered for the synchroniser
   assign pin_raw = {STRAP_MGMT_ADDRESS_BITS_IN, STRAP_PORT_A_IN, STRAP_PORT_B_IN};
   assign pin_rst_val = {DEF_ADDR, DEF_FIBER, DEF_AUTONEG, DEF_CAP,
                         DEF_FIBER, DEF_AUTONEG, DEF_CAP};

   // pins are asynchronous to the core clock; never reset, since the straps
   // must keep flowing through it while hardware reset is held
   rss_sync2 #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .clk_in(SYS_CLK_IN),
      .nrst_in(1'b1),
      .d_in(pin_raw),
      .rst_val_in(pin_rst_val),
      .q_out(pin_sync)
   );

   // sampling window: open while reset is low, closed by the first clock after release.
   // the async reset forces a constant; capture happens in the clocked path below.
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sampling <= 1'b1;
      end else begin
         sampling <= 1'b0; // window ends at release [R2]
      end
   end

   // strap capture runs off the free clock, not the reset, so it is not reset itself;
   // it tracks the synchronised pins only while the window is open
   always_ff @(posedge SYS_CLK_IN) begin
      if (sampling) begin
         phy_control_register <= pin_sync[11:8]; // [R1] [R3]
         strap_a <= pin_sync[7:4]; // [R1] [R7]
         strap_b <= pin_sync[3:0]; // [R1] [R7]
      end
      // otherwise hold: later pin activity is ignored [R13]
   end

   // resolve one port's configuration from its latched straps
   function automatic rss_port_cfg_t resolve(input logic [3:0] addr_hi,
                                             input logic port_sel,
                                             input rss_port_strap_t s);
      rss_port_cfg_t c;
      c = '0;
      c.mgmt_addr = {addr_hi, port_sel}; // bit zero unstrapped, port select [R3] [R4]
      c.fiber = s.fiber; // [R7]
      if (s.fiber) begin
         // autoneg and high capability are don't-care here [R11]
         c.autoneg = 1'b0; // [R12]
         c.capability = {1'b0, s.cap_low};
         c.full_duplex = s.cap_low; // [R10]
         c.speed100 = 1'b1; // [R12]
      end else begin
         c.autoneg = s.autoneg; // [R8]
         c.capability = {s.cap_high, s.cap_low}; // forced or advertised [R9]
         // high capability strap picks 100 mb/s, low picks full duplex
         c.full_duplex = s.cap_low; // [R9]
         c.speed100 = s.cap_high; // [R9]
      end
      return c;
   endfunction

   // port a even, port b odd
   always_comb begin
      next_cfg_a = resolve(phy_control_register, 1'b0, strap_a); // [R5]
      next_cfg_b = resolve(phy_control_register, 1'b1, strap_b); // [R6]
   end

   // configuration outputs registered; frozen with the straps
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         PORT_A_CFG_OUT <= '0;
         PORT_B_CFG_OUT <= '0;
         CFG_VALID_OUT <= 1'b0;
      end else begin
         PORT_A_CFG_OUT <= next_cfg_a; // [R8]
         PORT_B_CFG_OUT <= next_cfg_b; // [R8]
         CFG_VALID_OUT <= ~sampling; // [R13]
      end
   end

   // write address and data taken independently, in either order
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (AXIL_REQ_IN.awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= AXIL_REQ_IN.awaddr;
         end
         if (AXIL_REQ_IN.wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= AXIL_REQ_IN.wdata;
            w_strb <= AXIL_REQ_IN.wstrb;
         end
         if (bvalid && AXIL_REQ_IN.bready) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // response bundle packed in one place so each field has a single driver
   always_comb begin
      AXIL_RSP_OUT.awready = ~aw_held;
      AXIL_RSP_OUT.wready = ~w_held;
      AXIL_RSP_OUT.bvalid = bvalid;
      AXIL_RSP_OUT.bresp = bresp;
      AXIL_RSP_OUT.arready = ~rvalid;
      AXIL_RSP_OUT.rvalid = rvalid;
      AXIL_RSP_OUT.rdata = rdata;
      AXIL_RSP_OUT.rresp = rresp;
   end

   // write response and scratch register; strap registers are read only
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         bvalid <= 1'b0;
         bresp <= BRESP_OKAY;
         scratch <= SCRATCH_RST;
      end else if (bvalid) begin
         if (AXIL_REQ_IN.bready) begin
            bvalid <= 1'b0;
         end
      end else if (aw_held && w_held) begin
         bvalid <= 1'b1;
         if (aw_addr == OFS_SCRATCH) begin
            bresp <= BRESP_OKAY;
            for (int i = 0; i < 4; i++) begin
               if (w_strb[i]) begin
                  scratch[i*8 +: 8] <= w_data[i*8 +: 8];
               end
            end
         end else begin
            // latched configuration cannot be rewritten by software [R13]
            bresp <= BRESP_SLVERR;
         end
      end
   end

   // read mux
   always_comb begin
      next_rdata = '0;
      next_rresp = BRESP_OKAY;
      case (AXIL_REQ_IN.araddr)
         OFS_STRAP_CTRL: begin
            next_rdata[3:0] = phy_control_register; // [R3]
            next_rdata[F_LATCHED] = CFG_VALID_OUT;
         end
         OFS_PORT_A: begin
            next_rdata[F_SPEED100:F_ADDR_LSB] = {PORT_A_CFG_OUT.speed100,
               PORT_A_CFG_OUT.full_duplex, PORT_A_CFG_OUT.capability,
               PORT_A_CFG_OUT.autoneg, PORT_A_CFG_OUT.fiber, 3'h0,
               PORT_A_CFG_OUT.mgmt_addr};
         end
         OFS_PORT_B: begin
            next_rdata[F_SPEED100:F_ADDR_LSB] = {PORT_B_CFG_OUT.speed100,
               PORT_B_CFG_OUT.full_duplex, PORT_B_CFG_OUT.capability,
               PORT_B_CFG_OUT.autoneg, PORT_B_CFG_OUT.fiber, 3'h0,
               PORT_B_CFG_OUT.mgmt_addr};
         end
         OFS_SCRATCH: begin
            next_rdata = scratch;
         end
         default: begin
            next_rresp = BRESP_SLVERR;
         end
      endcase
   end

   // read channel: one cycle after the address is taken
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= BRESP_OKAY;
      end else if (rvalid) begin
         if (AXIL_REQ_IN.rready) begin
            rvalid <= 1'b0;
         end
      end else if (AXIL_REQ_IN.arvalid) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
endmodule // rss_top

// *** verif/rss_strap_pulls.sv ***
/*
 board pulls on the strap pins: a level per pin while reset is held.
 assumes the bench sets the levels before it lowers reset.
*/
`timescale 1ns/1ps
module rss_strap_pulls (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [11:0] lvl_in,
   output logic [11:0] pin_out
);
   // after release the pins carry data and leds, so they keep moving
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_out <= lvl_in;
      end else begin
         pin_out <= ~pin_out;
      end
   end
endmodule // rss_strap_pulls

// *** verif/rss_top_properties.sv ***
/*
 concurrent checks on the ports of rss_top.
 assumes straps are steady for at least four edges before reset release.
*/
`timescale 1ns/1ps
module rss_top_properties
   import rss_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   input wire logic [3:0] STRAP_MGMT_ADDRESS_BITS_IN,
   input wire rss_pkg::rss_port_strap_t STRAP_PORT_A_IN,
   input wire rss_pkg::rss_port_strap_t STRAP_PORT_B_IN,
   input wire rss_pkg::rss_axil_req_t AXIL_REQ_IN,
   input wire rss_pkg::rss_axil_rsp_t AXIL_RSP_OUT,
   input wire rss_pkg::rss_port_cfg_t PORT_A_CFG_OUT,
   input wire rss_pkg::rss_port_cfg_t PORT_B_CFG_OUT,
   input wire logic CFG_VALID_OUT
);
   default clocking cb_clk @(posedge SYS_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   rss_port_cfg_t ca, cb;
   logic [1:0] sa_cap, sb_cap;
   // short aliases keep the properties readable
   assign ca = PORT_A_CFG_OUT;
   assign cb = PORT_B_CFG_OUT;
   assign sa_cap = STRAP_PORT_A_IN[1:0];
   assign sb_cap = STRAP_PORT_B_IN[1:0];
   // past depth 4 lands inside reset, before the pins start moving
   property p_up; $rose(NRST_IN) |-> ##[1:2] CFG_VALID_OUT; endproperty
   property p_hold; CFG_VALID_OUT && $past(CFG_VALID_OUT) |-> $stable({ca, cb}); endproperty
   property p_addr_a; $rose(CFG_VALID_OUT) |-> ca.mgmt_addr == {$past(STRAP_MGMT_ADDRESS_BITS_IN, 4), 1'b0}; endproperty
   property p_addr_b; $rose(CFG_VALID_OUT) |-> cb.mgmt_addr == {$past(STRAP_MGMT_ADDRESS_BITS_IN, 4), 1'b1}; endproperty
   property p_fx_a;
      $rose(CFG_VALID_OUT) |-> ca.fiber == $past(STRAP_PORT_A_IN.fiber, 4)
         && ca.full_duplex == $past(STRAP_PORT_A_IN.cap_low, 4);
   endproperty
   property p_fx_b;
      $rose(CFG_VALID_OUT) |-> cb.fiber == $past(STRAP_PORT_B_IN.fiber, 4)
         && cb.full_duplex == $past(STRAP_PORT_B_IN.cap_low, 4);
   endproperty
   property p_an_a;
      $rose(CFG_VALID_OUT) && !ca.fiber |-> ca.capability == $past(sa_cap, 4)
         && ca.autoneg == $past(STRAP_PORT_A_IN.autoneg, 4);
   endproperty
   property p_an_b;
      $rose(CFG_VALID_OUT) && !cb.fiber |-> cb.capability == $past(sb_cap, 4)
         && cb.autoneg == $past(STRAP_PORT_B_IN.autoneg, 4);
   endproperty
   property p_fx_mode;
      CFG_VALID_OUT |-> (!ca.fiber || (ca.speed100 && !ca.autoneg && !ca.capability[1]))
         && (!cb.fiber || (cb.speed100 && !cb.autoneg && !cb.capability[1]));
   endproperty
   a_up: assert property (p_up) else $error("config not valid after reset");
   a_hold: assert property (p_hold) else $error("config moved");
   a_addr_a: assert property (p_addr_a) else $error("port a address");
   a_addr_b: assert property (p_addr_b) else $error("port b address");
   a_fx_a: assert property (p_fx_a) else $error("port a fiber or duplex");
   a_fx_b: assert property (p_fx_b) else $error("port b fiber or duplex");
   a_an_a: assert property (p_an_a) else $error("port a autoneg mode");
   a_an_b: assert property (p_an_b) else $error("port b autoneg mode");
   a_fx_mode: assert property (p_fx_mode) else $error("fiber mode speed");
   // main scenarios reached
   cover property ($rose(CFG_VALID_OUT) && ca.fiber);
   cover property ($rose(CFG_VALID_OUT) && cb.autoneg && !cb.fiber);
   cover property (AXIL_RSP_OUT.bvalid && AXIL_REQ_IN.bready && AXIL_RSP_OUT.bresp == BRESP_SLVERR);
endmodule // rss_top_properties

bind rss_top rss_top_properties chk_u (.SYS_CLK_IN, .NRST_IN, .STRAP_MGMT_ADDRESS_BITS_IN,
   .STRAP_PORT_A_IN, .STRAP_PORT_B_IN, .AXIL_REQ_IN, .AXIL_RSP_OUT, .PORT_A_CFG_OUT,
   .PORT_B_CFG_OUT, .CFG_VALID_OUT);

// *** verif/reset_strap_sampler_test.sv ***
/*
 self-checking bench for rss_top: straps per reset, status over axi4-lite.
 assumes the pull model above and the register map of the package.
*/
`timescale 1ns/1ps
module reset_strap_sampler_test;
   import rss_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, valid;
   logic [11:0] lvl = 12'h000, pins;
   rss_axil_req_t req = '0;
   rss_axil_rsp_t rsp;
   rss_port_cfg_t cfg_a, cfg_b;
   logic [31:0] d, w;
   logic [1:0] r;
   int error_cnt = 0, checks = 0, cyc = 0;
   logic [11:0] corner [5] = '{12'h000, 12'hfff, 12'h077, 12'h5a5, 12'ha3c};
   rss_top dut_u (.SYS_CLK_IN(clk), .NRST_IN(nrst), .STRAP_MGMT_ADDRESS_BITS_IN(pins[11:8]),
      .STRAP_PORT_A_IN(rss_port_strap_t'(pins[7:4])), .STRAP_PORT_B_IN(rss_port_strap_t'(pins[3:0])),
      .AXIL_REQ_IN(req), .AXIL_RSP_OUT(rsp), .PORT_A_CFG_OUT(cfg_a), .PORT_B_CFG_OUT(cfg_b),
      .CFG_VALID_OUT(valid));
   rss_strap_pulls pulls_u (.clk_in(clk), .nrst_in(nrst), .lvl_in(lvl), .pin_out(pins));
   initial begin
      forever #4 clk = ~clk;
   end
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic rss_port_cfg_t exp_cfg(logic [3:0] a, logic b, rss_port_strap_t s);
      // fiber drops autoneg and the high capability strap
      exp_cfg = {a, b, s.fiber, s.autoneg & ~s.fiber, s.cap_high & ~s.fiber, s.cap_low,
         s.cap_low, s.cap_high | s.fiber};
   endfunction
   function automatic logic [31:0] reg_word(rss_port_cfg_t c);
      reg_word = {18'h0, c.speed100, c.full_duplex, c.capability, c.autoneg, c.fiber, 3'h0,
         c.mgmt_addr};
   endfunction
   // handshake state sampled at the falling edge, acted on right after the rising one
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
      logic ta, tw, b = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= s;
      req.bready <= 1'b1;
      while (!b) begin
         @(negedge clk);
         ta = req.awvalid && rsp.awready;
         tw = req.wvalid && rsp.wready;
         b = rsp.bvalid && req.bready;
         r = rsp.bresp;
         @(posedge clk);
         if (ta) req.awvalid <= 1'b0;
         if (tw) req.wvalid <= 1'b0;
         if (b) req.bready <= 1'b0;
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic ta, rv = 1'b0;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      while (!rv) begin
         @(negedge clk);
         ta = req.arvalid && rsp.arready;
         rv = rsp.rvalid && req.rready;
         d = rsp.rdata;
         r = rsp.rresp;
         @(posedge clk);
         if (ta) req.arvalid <= 1'b0;
         if (rv) req.rready <= 1'b0;
      end
   endtask
   task automatic trial(input logic [11:0] v);
      rss_port_cfg_t ea, eb;
      ea = exp_cfg(v[11:8], 1'b0, v[7:4]);
      eb = exp_cfg(v[11:8], 1'b1, v[3:0]);
      @(posedge clk);
      lvl <= v;
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("cfg valid", 32'h1, valid);
      chk("port a cfg", ea, cfg_a);
      chk("port b cfg", eb, cfg_b);
      axi_rd(OFS_PORT_A);
      chk("port a reg", reg_word(ea), d);
      axi_rd(OFS_PORT_B);
      chk("port b reg", reg_word(eb), d);
      axi_rd(OFS_STRAP_CTRL);
      chk("strap ctrl reg", {15'h0, 1'b1, 12'h0, v[11:8]}, d);
      chk("port a held", ea, cfg_a);
      chk("port b held", eb, cfg_b);
   endtask
   initial begin
      void'($urandom(32'h28f9da3a));
      foreach (corner[i]) trial(corner[i]);
      w = $urandom;
      axi_wr(OFS_SCRATCH, w);
      chk("scratch wr resp", BRESP_OKAY, r);
      axi_rd(OFS_SCRATCH);
      chk("scratch rd", w, d);
      axi_wr(OFS_SCRATCH, ~w, 4'h5);
      axi_rd(OFS_SCRATCH);
      chk("scratch strobe", {w[31:24], ~w[23:16], w[15:8], ~w[7:0]}, d);
      axi_wr(OFS_PORT_A, ~w);
      chk("ro wr resp", BRESP_SLVERR, r);
      chk("cfg after wr", exp_cfg(4'ha, 1'b0, 4'h3), cfg_a);
      axi_rd(8'h10);
      chk("unmapped resp", BRESP_SLVERR, r);
      chk("unmapped data", 32'h0, d);
      trial(12'h3c3);
      axi_rd(OFS_SCRATCH);
      chk("scratch reset", SCRATCH_RST, d);
      repeat (8) trial(12'($urandom));
      conclude();
   end
endmodule // reset_strap_sampler_test
